// file: design/icsel_pkg.sv
`default_nettype none
package icsel_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [3:0] ICSEL_OFS_CTRL1 = 4'h0;
  localparam logic [3:0] ICSEL_OFS_CTRL2 = 4'h4;
  localparam logic [3:0] ICSEL_OFS_TRIM  = 4'h8;
  localparam logic [3:0] ICSEL_OFS_STAT  = 4'hC;

  ////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int ICSEL_SRC_BIT   = 6;
  localparam int ICSEL_REFERENCE_DIVIDER_SELECT_LSB  = 3;
  localparam int ICSEL_RSTEN_BIT = 0;
  localparam int ICSEL_BUS_DIVIDER_FIELD_LSB  = 6;
  localparam int ICSEL_LP_BIT    = 3;
  localparam int ICSEL_STAT_BIT  = 2;
  localparam int ICSEL_FTRIM_BIT = 0;

  localparam logic [7:0] ICSEL_CTRL1_ONES = 8'h06;

  ////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic       ICSEL_SRC_RST   = 1'b0;
  localparam logic [2:0] ICSEL_REFERENCE_DIVIDER_SELECT_RST  = 3'h0;
  localparam logic       ICSEL_RSTEN_RST = 1'b0;
  localparam logic [1:0] ICSEL_BUS_DIVIDER_FIELD_RST  = 2'h1;
  localparam logic       ICSEL_LP_RST    = 1'b0;
  localparam logic [7:0] ICSEL_TRIM_RST  = 8'h80;
  localparam logic       ICSEL_FTRIM_RST = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Counts.
  localparam int ICSEL_LOCK_RATIO = 512;
  localparam int ICSEL_LOCK_W     = 10;

  typedef enum logic [1:0] {
    ICSEL_ENGAGED,
    ICSEL_BYPASSED,
    ICSEL_BYP_LP,
    ICSEL_STOP
  } icsel_mode_e;

  typedef enum logic [1:0] {
    ICSEL_SW_IDLE,
    ICSEL_SW_DROP,
    ICSEL_SW_PICK
  } icsel_sw_e;

endpackage
`default_nettype wire

// file: design/icsel_top.sv
// Function
// R1: Selected source via divider drives system clock.
// R2: First control bits 1,2 read one.
// R3: Divider field 7:6 selects 1/2/4/8.
// R4: Reset enters loop engaged mode.
// R5: Debug clock is loop output halved.
// R6: Engaged mode: system and debug from loop.
// R7: Bypassed: loop runs, system from reference.
// R8: Low power bypass: loop off, no debug.
// R9: Stop: no system, no debug clock.
// R10: Source select bit 6 picks path.
// R11: Stop enable keeps reference running in stop.
// R12: Low power bit disables loop unless debugging; here only in bypass, engaged mode keeps the loop on.
// R13: Three bit reference divider selection.
// R14: Nine trim bits tune reference period.
// R15: No signal of this unit leaves chip.
// R16: Select and low power bit pick mode.
// R17: Loop locks to 512 times filter.
// R18: Divider changes take effect immediately.
// R19: Mode status follows synchronised source switch.
// R20: Glitch free source mux on both clocks.
`default_nettype none
module icsel_top
  import icsel_pkg::*;
#(
  parameter int LOCK_RATIO = icsel_pkg::ICSEL_LOCK_RATIO,
  parameter int LOCK_W     = icsel_pkg::ICSEL_LOCK_W
) (
  input  wire logic        clk_sys_i,          // System clock.
  input  wire logic        resetn_i,           // Sync reset, low.
  input  wire logic [3:0]  avs_address_i,      // Byte address.
  input  wire logic        avs_read_i,         // Read request.
  input  wire logic        avs_write_i,        // Write request.
  input  wire logic [31:0] avs_writedata_i,    // Write data.
  input  wire logic [3:0]  avs_byteenable_i,   // Byte lanes.
  output logic      [31:0] avs_readdata_o,     // Read data.
  output logic             avs_waitrequest_o,  // Stall.
  input  wire logic        loop_clk_i,         // Loop oscillator.
  input  wire logic        ref_clk_i,          // Internal reference.
  input  wire logic        stop_i,             // Chip in stop.
  input  wire logic        bdm_active_i,       // Debug mode active.
  output logic             system_clock_out_o, // System clock out.
  output logic             debug_clock_o,      // Debug clock.
  output logic             loop_enable_o,      // Loop powered.
  output logic             ref_enable_o,       // Reference powered.
  output logic             loop_locked_o,      // Loop at ratio.
  output logic      [2:0]  ref_div_sel_o,      // Reference divider.
  output logic      [8:0]  trim_o,             // Reference trim.
  output icsel_pkg::icsel_mode_e clock_mode_o  // Active mode.
);
  import icsel_pkg::*;

  if (LOCK_RATIO < 1 || LOCK_RATIO >= (1 << LOCK_W)) begin : g_chk
    $error("LOCK_RATIO does not fit LOCK_W");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and bus slave.

  logic       src_q;
  logic       src_d;
  logic [2:0] reference_divider_select_q;
  logic [2:0] reference_divider_select_d;
  logic       rsten_q;
  logic       rsten_d;
  logic [1:0] bus_divider_field_q;
  logic [1:0] bus_divider_field_d;
  logic       lp_q;
  logic       lp_d;
  logic [7:0] trim_q;
  logic [7:0] trim_d;
  logic       ftrim_q;
  logic       ftrim_d;
  logic       ack_q;
  logic       ack_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       cur_q;
  logic       req;
  logic       wr_en;
  logic [7:0] wdat;
  logic [7:0] rd_val;

  assign req   = avs_read_i | avs_write_i;
  assign wr_en = avs_write_i & ack_q & avs_byteenable_i[0];
  assign wdat  = avs_writedata_i[7:0];

  // One wait state: the read value is captured while stalled, so it
  // stands on the same edge at which waitrequest is seen low.
  assign avs_waitrequest_o = req & ~ack_q;

  always_comb begin
    rd_val = 8'h00;
    case (avs_address_i)
      ICSEL_OFS_CTRL1: begin
        rd_val[ICSEL_SRC_BIT]             = src_q;
        rd_val[ICSEL_REFERENCE_DIVIDER_SELECT_LSB +: 3]       = reference_divider_select_q;
        rd_val[ICSEL_RSTEN_BIT]           = rsten_q;
        rd_val = rd_val | ICSEL_CTRL1_ONES; // R2
      end
      ICSEL_OFS_CTRL2: begin
        rd_val[ICSEL_BUS_DIVIDER_FIELD_LSB +: 2] = bus_divider_field_q;
        rd_val[ICSEL_LP_BIT]        = lp_q;
      end
      ICSEL_OFS_TRIM: begin
        rd_val = trim_q;
      end
      ICSEL_OFS_STAT: begin
        rd_val[ICSEL_STAT_BIT]  = cur_q; // R19
        rd_val[ICSEL_FTRIM_BIT] = ftrim_q;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  always_comb begin
    src_d   = src_q;
    reference_divider_select_d  = reference_divider_select_q;
    rsten_d = rsten_q;
    bus_divider_field_d  = bus_divider_field_q;
    lp_d    = lp_q;
    trim_d  = trim_q;
    ftrim_d = ftrim_q;
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read_i && !ack_q) begin
      rdata_d = rd_val;
    end
    if (wr_en) begin
      case (avs_address_i)
        ICSEL_OFS_CTRL1: begin
          src_d   = wdat[ICSEL_SRC_BIT]; // R10
          reference_divider_select_d  = wdat[ICSEL_REFERENCE_DIVIDER_SELECT_LSB +: 3]; // R13
          rsten_d = wdat[ICSEL_RSTEN_BIT];
        end
        ICSEL_OFS_CTRL2: begin
          bus_divider_field_d = wdat[ICSEL_BUS_DIVIDER_FIELD_LSB +: 2]; // R3
          lp_d   = wdat[ICSEL_LP_BIT];
        end
        ICSEL_OFS_TRIM: begin
          trim_d = wdat; // R14
        end
        ICSEL_OFS_STAT: begin
          ftrim_d = wdat[ICSEL_FTRIM_BIT]; // R14
        end
        default: begin
          ack_d = req & ~ack_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      src_q   <= ICSEL_SRC_RST; // R4
      reference_divider_select_q  <= ICSEL_REFERENCE_DIVIDER_SELECT_RST;
      rsten_q <= ICSEL_RSTEN_RST;
      bus_divider_field_q  <= ICSEL_BUS_DIVIDER_FIELD_RST; // R3
      lp_q    <= ICSEL_LP_RST;
      trim_q  <= ICSEL_TRIM_RST;
      ftrim_q <= ICSEL_FTRIM_RST;
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      src_q   <= src_d;
      reference_divider_select_q  <= reference_divider_select_d;
      rsten_q <= rsten_d;
      bus_divider_field_q  <= bus_divider_field_d;
      lp_q    <= lp_d;
      trim_q  <= trim_d;
      ftrim_q <= ftrim_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode and power control.

  icsel_mode_e mode_q;
  icsel_mode_e mode_d;
  logic        loop_en_q;
  logic        loop_en_d;
  logic        ref_en_q;
  logic        ref_en_d;

  always_comb begin
    if (stop_i) begin
      mode_d = ICSEL_STOP; // R9
    end else if (!src_q) begin
      mode_d = ICSEL_ENGAGED; // R16
    end else if (lp_q) begin
      mode_d = ICSEL_BYP_LP; // R16
    end else begin
      mode_d = ICSEL_BYPASSED; // R16
    end
    // The loop stays on in bypass so a later switch to engaged finds it
    // already settled; low power trades that for current.
    loop_en_d = ~stop_i & (~src_q | ~lp_q | bdm_active_i); // R6 R7 R8 R12
    // The output enable of the reference reads as set and the unit is
    // always in a run mode before stop, so only the stop enable counts.
    ref_en_d = ~stop_i | rsten_q; // R11
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mode_q    <= ICSEL_ENGAGED; // R4
      loop_en_q <= 1'b1;
      ref_en_q  <= 1'b1;
    end else begin
      mode_q    <= mode_d;
      loop_en_q <= loop_en_d;
      ref_en_q  <= ref_en_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Glitch free source switch.

  icsel_sw_e sw_q;
  icsel_sw_e sw_d;
  logic      cur_d;
  logic      nxt_q;
  logic      nxt_d;
  logic      en_l_q;
  logic      en_l_d;
  logic      en_r_q;
  logic      en_r_d;
  logic      lclk_q;
  logic      rclk_q;
  logic      lclk;
  logic      cur_lvl;
  logic      nxt_lvl;

  assign lclk    = loop_clk_i & loop_en_q;
  assign cur_lvl = cur_q ? ref_clk_i : lclk;
  assign nxt_lvl = nxt_q ? ref_clk_i : lclk;

  // A gate only opens or closes while its own clock is low, so no
  // runt pulse can reach the divider.
  always_comb begin
    sw_d   = sw_q;
    cur_d  = cur_q;
    nxt_d  = nxt_q;
    en_l_d = en_l_q;
    en_r_d = en_r_q;
    case (sw_q)
      ICSEL_SW_IDLE: begin
        if (src_q != cur_q) begin
          nxt_d = src_q; // R10
          sw_d  = ICSEL_SW_DROP;
        end
      end
      ICSEL_SW_DROP: begin
        if (!cur_lvl) begin
          en_l_d = 1'b0; // R20
          en_r_d = 1'b0; // R20
          sw_d   = ICSEL_SW_PICK;
        end
      end
      ICSEL_SW_PICK: begin
        if (!nxt_lvl) begin
          en_l_d = ~nxt_q; // R20
          en_r_d = nxt_q; // R20
          cur_d  = nxt_q; // R19
          sw_d   = ICSEL_SW_IDLE;
        end
      end
      default: begin
        sw_d = ICSEL_SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sw_q   <= ICSEL_SW_IDLE;
      cur_q  <= ICSEL_SRC_RST; // R4
      nxt_q  <= ICSEL_SRC_RST;
      en_l_q <= 1'b1;
      en_r_q <= 1'b0;
      lclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      sw_q   <= sw_d;
      cur_q  <= cur_d;
      nxt_q  <= nxt_d;
      en_l_q <= en_l_d;
      en_r_q <= en_r_d;
      lclk_q <= lclk;
      rclk_q <= ref_clk_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus divider and clock outputs.

  logic       mux_clk;
  logic       mux_p_q;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       sys_q;
  logic       sys_d;
  logic       dbg_q;
  logic       dbg_d;
  logic       l_rise;

  assign mux_clk = (en_l_q & lclk_q) | (en_r_q & rclk_q);
  assign l_rise  = lclk & ~lclk_q;

  always_comb begin
    cnt_d = cnt_q;
    if (mux_clk && !mux_p_q) begin
      cnt_d = cnt_q + 3'h1;
    end
    // The field is decoded every cycle, so a new ratio acts at once.
    case (bus_divider_field_q) // R18
      2'h0:    sys_d = mux_clk; // R3
      2'h1:    sys_d = cnt_q[0]; // R3
      2'h2:    sys_d = cnt_q[1]; // R3
      default: sys_d = cnt_q[2]; // R3
    endcase
    if (stop_i) begin
      sys_d = 1'b0; // R9
    end
    dbg_d = 1'b0; // R8 R9
    if (loop_en_q) begin
      dbg_d = l_rise ? ~dbg_q : dbg_q; // R5 R6 R7
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mux_p_q <= 1'b0;
      cnt_q   <= 3'h0;
      sys_q   <= 1'b0;
      dbg_q   <= 1'b0;
    end else begin
      mux_p_q <= mux_clk;
      cnt_q   <= cnt_d;
      sys_q   <= sys_d; // R1
      dbg_q   <= dbg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference divider and loop lock meter.

  logic [6:0]        fcnt_q;
  logic [6:0]        fcnt_d;
  logic [6:0]        flim;
  logic [LOCK_W-1:0] mcnt_q;
  logic [LOCK_W-1:0] mcnt_d;
  logic              lock_q;
  logic              lock_d;
  logic              r_rise;
  logic              tick;

  assign r_rise = ref_clk_i & ~rclk_q;
  assign flim   = 7'((8'h01 << reference_divider_select_q) - 8'h01); // R13
  // Compare with at-or-above so that lowering the divider while the
  // count stands past the new limit ends the period at the next reference edge, instead of
  // waiting for the counter to wrap.
  assign tick   = r_rise & (fcnt_q >= flim);

  // The meter only counts edges seen at the system clock rate, so it
  // reads true only while both sources run well below that rate.
  always_comb begin
    fcnt_d = fcnt_q;
    if (r_rise) begin
      fcnt_d = tick ? 7'h00 : fcnt_q + 7'h01; // R13
    end
    mcnt_d = mcnt_q;
    if (l_rise && !(&mcnt_q)) begin
      mcnt_d = mcnt_q + 1'b1;
    end
    lock_d = lock_q;
    if (tick) begin
      lock_d = (mcnt_q == LOCK_W'(LOCK_RATIO)); // R17
      mcnt_d = {{(LOCK_W-1){1'b0}}, l_rise};
    end
    if (!loop_en_q) begin
      lock_d = 1'b0;
      mcnt_d = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      fcnt_q <= 7'h00;
      mcnt_q <= '0;
      lock_q <= 1'b0;
    end else begin
      fcnt_q <= fcnt_d;
      mcnt_q <= mcnt_d;
      lock_q <= lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs feed on-chip logic only.

  assign avs_readdata_o     = {24'h00_0000, rdata_q}; // R15
  assign system_clock_out_o = sys_q; // R1 R15
  assign debug_clock_o      = dbg_q; // R5
  assign loop_enable_o      = loop_en_q; // R12
  assign ref_enable_o       = ref_en_q; // R11
  assign loop_locked_o      = lock_q; // R17
  assign ref_div_sel_o      = reference_divider_select_q; // R13
  assign trim_o             = {trim_q, ftrim_q}; // R14
  assign clock_mode_o       = mode_q; // R16

endmodule
`default_nettype wire

// file: tb/icsel_asserts.sv
`default_nettype none
module icsel_asserts
  import icsel_pkg::*;
(
  input wire logic        clk_sys_i,          // Clock.
  input wire logic        resetn_i,           // Reset.
  input wire logic [3:0]  avs_address_i,      // Address.
  input wire logic        avs_read_i,         // Read.
  input wire logic [31:0] avs_readdata_o,     // Read data.
  input wire logic        avs_waitrequest_o,  // Stall.
  input wire logic        stop_i,             // Stop.
  input wire logic        bdm_active_i,       // Debug on.
  input wire logic        system_clock_out_o, // System clock.
  input wire logic        debug_clock_o,      // Debug clock.
  input wire logic        loop_enable_o,      // Loop on.
  input wire logic        ref_enable_o,       // Reference on.
  input wire icsel_pkg::icsel_mode_e clock_mode_o // Mode.
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  a_reset_engaged: assert property (
    $rose(resetn_i) |-> clock_mode_o == ICSEL_ENGAGED && loop_enable_o)
    else $error("mode after reset not engaged");
  a_ctrl1_ones: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == ICSEL_OFS_CTRL1
    |-> avs_readdata_o[2:1] == 2'b11) else $error("ctrl1 bits 2:1 not one");
  a_stop_quiet: assert property (
    stop_i && $past(stop_i) |-> !system_clock_out_o
    && clock_mode_o == ICSEL_STOP) else $error("system clock in stop");
  a_stop_loop_off: assert property (
    stop_i [*3] |-> !loop_enable_o && !debug_clock_o)
    else $error("loop or debug clock in stop");
  a_engaged_loop: assert property (
    clock_mode_o == ICSEL_ENGAGED |-> loop_enable_o)
    else $error("loop off while engaged");
  a_bypass_loop: assert property (
    clock_mode_o == ICSEL_BYPASSED |-> loop_enable_o)
    else $error("loop off while bypassed");
  a_lowpwr_off: assert property (
    clock_mode_o == ICSEL_BYP_LP && !$past(bdm_active_i) |-> !loop_enable_o)
    else $error("loop on in low power");
  a_lowpwr_bdm: assert property (
    clock_mode_o == ICSEL_BYP_LP && $past(bdm_active_i) |-> loop_enable_o)
    else $error("loop off while debugging");
  a_run_ref_on: assert property (
    !$past(stop_i) |-> ref_enable_o) else $error("reference off in run");
  a_debug_off: assert property (
    !loop_enable_o [*3] |-> !debug_clock_o)
    else $error("debug clock with loop off");
endmodule

bind icsel_top icsel_asserts u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .stop_i(stop_i), .bdm_active_i(bdm_active_i),
  .system_clock_out_o(system_clock_out_o), .debug_clock_o(debug_clock_o),
  .loop_enable_o(loop_enable_o), .ref_enable_o(ref_enable_o),
  .clock_mode_o(clock_mode_o));
`default_nettype wire

// file: tb/icsel_top_bench.sv
`default_nettype none
module icsel_top_bench;
  import icsel_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys_i;
  logic        resetn_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic        stop_i = 1'b0;
  logic        bdm_active_i = 1'b0;
  logic [4:0]  cnt_q = 5'h00;
  logic        loop_clk_i = 1'b0;
  logic        ref_clk_i = 1'b0;
  logic [31:0] avs_readdata_o, rd;
  logic        avs_waitrequest_o, system_clock_out_o, debug_clock_o;
  logic        loop_enable_o, ref_enable_o, loop_locked_o;
  logic [2:0]  ref_div_sel_o;
  logic [8:0]  trim_o;
  icsel_mode_e clock_mode_o;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          ns, nd;

  // Short lock ratio: loop period 4 cycles, reference 32, so 8 per tick.
  icsel_top #(.LOCK_RATIO(8), .LOCK_W(4)) DUT (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .loop_clk_i(loop_clk_i),
    .ref_clk_i(ref_clk_i), .stop_i(stop_i), .bdm_active_i(bdm_active_i),
    .system_clock_out_o(system_clock_out_o), .debug_clock_o(debug_clock_o),
    .loop_enable_o(loop_enable_o), .ref_enable_o(ref_enable_o),
    .loop_locked_o(loop_locked_o), .ref_div_sel_o(ref_div_sel_o),
    .trim_o(trim_o), .clock_mode_o(clock_mode_o));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    cnt_q <= cnt_q + 5'd1;
    loop_clk_i <= cnt_q[1];
    ref_clk_i <= cnt_q[4];
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Counts compare within a tolerance, since phase at start is unknown.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g, input int tol);
    n_tests++;
    if (tol == 0 ? g !== e : (g > e + tol || g + tol < e)) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic [3:0] a, input logic w,
                      input logic [7:0] d, input logic [3:0] be);
    int i;
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h00_0000, d};
    avs_byteenable_i <= be;
    i = 0;
    // Waitrequest and read data are taken at the rising edge itself,
    // before that edge's register updates land.
    do begin
      @(posedge clk_sys_i);
      i++;
    end while (avs_waitrequest_o !== 1'b0 && i < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d, 4'h1);
  endtask

  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [7:0] e);
    xfer(a, 1'b0, 8'h00, 4'h1);
    chk(nm, {24'h00_0000, e}, rd, 0);
  endtask

  task automatic meas;
    logic ps, pd;
    ns = 0;
    nd = 0;
    ps = system_clock_out_o;
    pd = debug_clock_o;
    repeat (512) begin
      @(negedge clk_sys_i);
      if (system_clock_out_o && !ps) ns++;
      if (debug_clock_o && !pd) nd++;
      ps = system_clock_out_o;
      pd = debug_clock_o;
    end
    @(posedge clk_sys_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    chk("mode", ICSEL_ENGAGED, clock_mode_o, 0);
    chk("trim_o", 9'h100, trim_o, 0);
    rdc("ctrl1", ICSEL_OFS_CTRL1, 8'h06);
    rdc("ctrl2", ICSEL_OFS_CTRL2, 8'h40);
    rdc("trim", ICSEL_OFS_TRIM, 8'h80);
    rdc("stat", ICSEL_OFS_STAT, 8'h00);
    wr(4'h2, 8'hFF);
    rdc("unmapped", 4'h2, 8'h00);
    wr(ICSEL_OFS_CTRL1, 8'h39);
    rdc("ctrl1", ICSEL_OFS_CTRL1, 8'h3F);
    chk("reference_divider_select", 3'h7, ref_div_sel_o, 0);
    xfer(ICSEL_OFS_CTRL2, 1'b1, 8'h00, 4'h0);
    rdc("ctrl2", ICSEL_OFS_CTRL2, 8'h40);
    wr(ICSEL_OFS_TRIM, 8'h5A);
    wr(ICSEL_OFS_STAT, 8'h05);
    rdc("stat", ICSEL_OFS_STAT, 8'h01);
    chk("trim_o", 9'h0B5, trim_o, 0);
    wr(ICSEL_OFS_CTRL1, 8'h00);
    repeat (300) @(posedge clk_sys_i);
    chk("locked", 1'b1, loop_locked_o, 0);
    wr(ICSEL_OFS_CTRL1, 8'h08);
    repeat (300) @(posedge clk_sys_i);
    chk("locked", 1'b0, loop_locked_o, 0);
    wr(ICSEL_OFS_CTRL1, 8'h00);
    for (int b = 0; b < 4; b++) begin
      wr(ICSEL_OFS_CTRL2, {b[1:0], 6'h00});
      meas();
      chk("sys", 128 >> b, ns, 2);
      chk("dbg", 64, nd, 2);
    end
    wr(ICSEL_OFS_CTRL2, 8'h00);
    wr(ICSEL_OFS_CTRL1, 8'h40);
    rdc("stat", ICSEL_OFS_STAT, 8'h01);
    repeat (100) @(posedge clk_sys_i);
    rdc("stat", ICSEL_OFS_STAT, 8'h05);
    chk("mode", ICSEL_BYPASSED, clock_mode_o, 0);
    meas();
    chk("sys", 16, ns, 1);
    chk("dbg", 64, nd, 2);
    wr(ICSEL_OFS_CTRL2, 8'h08);
    // Mode and loop enable are registered one cycle after the field.
    repeat (2) @(posedge clk_sys_i);
    chk("mode", ICSEL_BYP_LP, clock_mode_o, 0);
    chk("loop_en", 1'b0, loop_enable_o, 0);
    meas();
    chk("sys", 16, ns, 1);
    chk("dbg", 0, nd, 0);
    bdm_active_i <= 1'b1;
    meas();
    chk("loop_en", 1'b1, loop_enable_o, 0);
    chk("dbg", 64, nd, 2);
    bdm_active_i <= 1'b0;
    stop_i <= 1'b1;
    meas();
    chk("mode", ICSEL_STOP, clock_mode_o, 0);
    chk("sys", 0, ns, 1);
    chk("dbg", 0, nd, 1);
    chk("ref_en", 1'b0, ref_enable_o, 0);
    wr(ICSEL_OFS_CTRL1, 8'h41);
    repeat (2) @(posedge clk_sys_i);
    chk("ref_en", 1'b1, ref_enable_o, 0);
    stop_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    chk("mode", ICSEL_BYP_LP, clock_mode_o, 0);
    wr(ICSEL_OFS_CTRL1, 8'h00);
    wr(ICSEL_OFS_CTRL2, 8'hC0);
    repeat (100) @(posedge clk_sys_i);
    rdc("stat", ICSEL_OFS_STAT, 8'h01);
    chk("mode", ICSEL_ENGAGED, clock_mode_o, 0);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc("ctrl2", ICSEL_OFS_CTRL2, 8'h40);
    chk("mode", ICSEL_ENGAGED, clock_mode_o, 0);
    print_verdict();
  end
endmodule
`default_nettype wire
